// file: core/csrl_latch.sv
// Comparator SR latch with software pulses, periodic set clock, output multiplexer and Avalon-MM registers.
//
// Contract
// - Set input is high when comparator 1 is high or software set pulse written; the code passes comparator 1 only while the set enable bit is set.
// - Reset input is high when comparator 2 is high or software reset pulse written; the code passes comparator 2 only while the reset enable bit is set.
// - Set and reset are active high; latch holds state between them.
// - Both inputs high forces and keeps the reset state.
// - Software set and reset pulse bits clear themselves after one action.
// - With set clock enabled periodic pulses hit set input; otherwise none.
// - Two-bit rate field chooses the set clock frequency.
// - Two-bit select routes one of four signal pairs to the port outputs.
// - After reset the select passes both raw comparator results.
// - Latch selection is independent of comparator on or off state.
//
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module csrl_latch
    import csrl_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        cmp1_result,
    input  wire logic        cmp2_result,
    output csrl_port_t       port_out,
    output logic             latch_q
);

    // ----------------------------------------
    // Register storage and bus decode
    // ----------------------------------------
    logic [7:0] comparator1_control;
    logic [7:0] comparator2_control;
    logic [7:0] latch_control;
    logic [7:0] latch_clock_rate;
    logic       answered;
    logic [7:0] div_count;
    logic       set_tick;
    csrl_req_t  req;

    // Bus signals bundled for decoding.
    assign req = '{address: avs_address, read: avs_read, write: avs_write,
                   writedata: avs_writedata, byteenable: avs_byteenable};

    // One wait state each access; a write lands only at the edge where waitrequest is low.
    assign answered = ~avs_waitrequest;
    wire       accept    = (req.read | req.write) & ~answered;
    wire       xfer      = (req.read | req.write) & answered;
    wire       wr_go     = xfer & req.write & req.byteenable[0];
    wire       wr_cmp1   = wr_go & (req.address == CSRL_ADDR_CMP1_CTRL);
    wire       wr_cmp2   = wr_go & (req.address == CSRL_ADDR_CMP2_CTRL);
    wire       wr_latch  = wr_go & (req.address == CSRL_ADDR_LATCH_CTRL);
    wire       wr_rate   = wr_go & (req.address == CSRL_ADDR_CLOCK_RATE);
    wire [7:0] wdata     = req.writedata[7:0];

    // Live comparator results shown in the result bit position; unmapped reads return zero.
    wire [7:0] rd_cmp1   = (comparator1_control & CSRL_CMP_WMASK)
                           | (8'(cmp1_result) << CSRL_CMP_RESULT_BIT);
    wire [7:0] rd_cmp2   = (comparator2_control & CSRL_CMP_WMASK)
                           | (8'(cmp2_result) << CSRL_CMP_RESULT_BIT);
    wire [7:0] rd_sel    = (req.address == CSRL_ADDR_CMP1_CTRL)  ? rd_cmp1 :
                           (req.address == CSRL_ADDR_CMP2_CTRL)  ? rd_cmp2 :
                           (req.address == CSRL_ADDR_LATCH_CTRL) ? latch_control :
                           (req.address == CSRL_ADDR_CLOCK_RATE) ? latch_clock_rate : 8'h00;

    // Waitrequest drops for exactly one cycle, the cycle after a request appears.
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= CSRL_ZERO_WORD;
        end
        else
        begin
            avs_waitrequest <= ~accept;
            avs_readdata    <= (accept & req.read) ? {24'h00_0000, rd_sel} : CSRL_ZERO_WORD;
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    wire pulse_set_bit = latch_control[CSRL_PULSE_SET_BIT];
    wire pulse_rst_bit = latch_control[CSRL_PULSE_RST_BIT];

    // Pulse bits are stored for one cycle only, then clear by themselves.
    wire [7:0] next_latch_control = wr_latch
        ? ((latch_control & ~CSRL_LATCH_WMASK) | (wdata & CSRL_LATCH_WMASK)
           | (wdata & ((8'h01 << CSRL_PULSE_SET_BIT) | (8'h01 << CSRL_PULSE_RST_BIT))))
        : (latch_control & CSRL_LATCH_WMASK);

    // Register writes; all registers return to zero on reset.
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            comparator1_control <= CSRL_RESET_VALUE;
            comparator2_control <= CSRL_RESET_VALUE;
            latch_control       <= CSRL_RESET_VALUE;
            latch_clock_rate    <= CSRL_RESET_VALUE;
        end
        else
        begin
            if (wr_cmp1)
                comparator1_control <= wdata & CSRL_CMP_WMASK;
            if (wr_cmp2)
                comparator2_control <= wdata & CSRL_CMP_WMASK;
            latch_control <= next_latch_control;
            if (wr_rate)
                latch_clock_rate <= wdata & CSRL_RATE_WMASK;
        end
    end

    // ----------------------------------------
    // Set clock divider
    // ----------------------------------------
    wire [1:0] set_clock_rate_sel = {latch_clock_rate[CSRL_RATE_HI_BIT], latch_clock_rate[CSRL_RATE_LO_BIT]};
    wire       set_clock_enable   = latch_control[CSRL_CLK_EN_BIT];
    wire [7:0] div_limit = (set_clock_rate_sel == 2'h0) ? CSRL_DIV_RATE0 :
                           (set_clock_rate_sel == 2'h1) ? CSRL_DIV_RATE1 :
                           (set_clock_rate_sel == 2'h2) ? CSRL_DIV_RATE2 : CSRL_DIV_RATE3;

    // Counter wraps at the selected limit and emits a one-cycle set tick when enabled.
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            div_count <= CSRL_DIV_ZERO;
            set_tick  <= 1'b0;
        end
        else if (!set_clock_enable)
        begin
            div_count <= CSRL_DIV_ZERO;
            set_tick  <= 1'b0;
        end
        else
        begin
            div_count <= (div_count >= div_limit) ? CSRL_DIV_ZERO : div_count + 8'h01;
            set_tick  <= (div_count >= div_limit);
        end
    end

    // ----------------------------------------
    // Latch core
    // ----------------------------------------
    // Comparator paths are gated by their enables; comparator on bits play no part here.
    wire set_in = (cmp1_result & latch_control[CSRL_SET_EN_BIT]) | pulse_set_bit | set_tick;
    wire rst_in = (cmp2_result & latch_control[CSRL_RST_EN_BIT]) | pulse_rst_bit;

    // State holds until an input is high; reset wins a tie.
    wire next_q = rst_in ? 1'b0 : (set_in ? 1'b1 : latch_q);

    always_ff @(posedge mclk)
    begin
        if (!nrst)
            latch_q <= 1'b0;
        else
            latch_q <= next_q;
    end

    // ----------------------------------------
    // Output multiplexer
    // ----------------------------------------
    csrl_sel_t sel;
    logic      mux1;
    logic      mux2;

    assign sel = csrl_sel_t'({latch_control[CSRL_SEL_HI_BIT], latch_control[CSRL_SEL_LO_BIT]});

    // Choose the pair routed to the two port outputs.
    always_comb
    begin
        case (sel)
            CSRL_SEL_BOTH_CMP:
            begin
                mux1 = cmp1_result;
                mux2 = cmp2_result;
            end
            CSRL_SEL_C1_Q:
            begin
                mux1 = cmp1_result;
                mux2 = next_q;
            end
            CSRL_SEL_C2_Q:
            begin
                mux1 = next_q;
                mux2 = cmp2_result;
            end
            CSRL_SEL_Q_QN:
            begin
                mux1 = next_q;
                mux2 = ~next_q;
            end
            default:
            begin
                mux1 = cmp1_result;
                mux2 = cmp2_result;
            end
        endcase
    end

    // Port outputs registered; enables follow the comparator output enable bits.
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            port_out <= '0;
        else
            port_out <= '{out1: mux1, out2: mux2,
                          oe1: comparator1_control[CSRL_CMP_OE_BIT],
                          oe2: comparator2_control[CSRL_CMP_OE_BIT]};
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_reset_dominant: assert property (@(posedge mclk) disable iff (!nrst)
        rst_in |=> !latch_q) else $error("Reset input did not clear latch.");
    a_set_path: assert property (@(posedge mclk) disable iff (!nrst)
        (set_in && !rst_in) |=> latch_q) else $error("Set input did not set latch.");
    a_comp_reset: assert property (@(posedge mclk) disable iff (!nrst)
        (cmp2_result && latch_control[CSRL_RST_EN_BIT]) |=> !latch_q)
        else $error("Comparator 2 did not reset latch.");
    a_latch_hold: assert property (@(posedge mclk) disable iff (!nrst)
        (!set_in && !rst_in) |=> $stable(latch_q)) else $error("Latch changed without input.");
    a_pulse_clears: assert property (@(posedge mclk) disable iff (!nrst)
        (pulse_set_bit && !wr_latch) |=> !pulse_set_bit) else $error("Set pulse bit stuck.");
    a_no_tick_off: assert property (@(posedge mclk) disable iff (!nrst)
        !set_clock_enable |=> !set_tick) else $error("Set tick while disabled.");
    a_tick_period: assert property (@(posedge mclk) disable iff (!nrst)
        (set_tick && set_clock_enable && set_clock_rate_sel == 2'h0 && !wr_latch && !wr_rate)
        |=> !set_tick [*3] ##1 (set_tick || !set_clock_enable || set_clock_rate_sel != 2'h0))
        else $error("Set clock period wrong for rate zero.");
    a_mux_latch: assert property (@(posedge mclk) disable iff (!nrst)
        (sel == CSRL_SEL_Q_QN) |=> (port_out.out1 == latch_q && port_out.out2 == !latch_q))
        else $error("Latch-only output pair wrong.");
    a_mux_default: assert property (@(posedge mclk) disable iff (!nrst)
        (sel == CSRL_SEL_BOTH_CMP) |=> (port_out.out1 == $past(cmp1_result)))
        else $error("Default mode did not pass comparator 1.");
    a_reset_select: assert property (@(posedge mclk)
        !nrst |=> (latch_control == CSRL_RESET_VALUE)) else $error("Select not cleared by reset.");

    c_latch_set: cover property (@(posedge mclk) disable iff (!nrst) $rose(latch_q));
    c_tie_reset: cover property (@(posedge mclk) disable iff (!nrst) set_in && rst_in);
    c_tick: cover property (@(posedge mclk) disable iff (!nrst) set_tick);
    c_mode_c2q: cover property (@(posedge mclk) disable iff (!nrst) sel == CSRL_SEL_C2_Q);

endmodule

// file: pkg/csrl_pkg.sv
// Package with register map, field layout and carrier types of the comparator SR latch block.
package csrl_pkg;

    // ----------------------------------------
    // Register map (word index times four)
    // ----------------------------------------
    localparam logic [3:0] CSRL_ADDR_CMP1_CTRL   = 4'h0;
    localparam logic [3:0] CSRL_ADDR_CMP2_CTRL   = 4'h4;
    localparam logic [3:0] CSRL_ADDR_LATCH_CTRL  = 4'h8;
    localparam logic [3:0] CSRL_ADDR_CLOCK_RATE  = 4'hC;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CSRL_CMP_ON_BIT      = 7;
    localparam int CSRL_CMP_RESULT_BIT  = 6;
    localparam int CSRL_CMP_OE_BIT      = 5;
    localparam int CSRL_SEL_HI_BIT      = 7;
    localparam int CSRL_SEL_LO_BIT      = 6;
    localparam int CSRL_SET_EN_BIT      = 5;
    localparam int CSRL_RST_EN_BIT      = 4;
    localparam int CSRL_PULSE_SET_BIT   = 3;
    localparam int CSRL_PULSE_RST_BIT   = 2;
    localparam int CSRL_CLK_EN_BIT      = 0;
    localparam int CSRL_RATE_HI_BIT     = 7;
    localparam int CSRL_RATE_LO_BIT     = 6;

    // ----------------------------------------
    // Reset values and writable masks
    // ----------------------------------------
    localparam logic [7:0] CSRL_RESET_VALUE  = 8'h00;
    localparam logic [7:0] CSRL_CMP_WMASK    = 8'hBF;
    localparam logic [7:0] CSRL_LATCH_WMASK  = 8'hF1;
    localparam logic [7:0] CSRL_RATE_WMASK   = 8'hC0;
    localparam logic [31:0] CSRL_ZERO_WORD   = 32'h0000_0000;

    // ----------------------------------------
    // Set clock divider limits per rate code (period is limit plus one)
    // ----------------------------------------
    localparam logic [7:0] CSRL_DIV_RATE0 = 8'h03;
    localparam logic [7:0] CSRL_DIV_RATE1 = 8'h0F;
    localparam logic [7:0] CSRL_DIV_RATE2 = 8'h3F;
    localparam logic [7:0] CSRL_DIV_RATE3 = 8'hFF;
    localparam logic [7:0] CSRL_DIV_ZERO  = 8'h00;

    // Output select codes.
    typedef enum logic [1:0]
    {
        CSRL_SEL_BOTH_CMP = 2'h0,
        CSRL_SEL_C1_Q     = 2'h1,
        CSRL_SEL_C2_Q     = 2'h2,
        CSRL_SEL_Q_QN     = 2'h3
    } csrl_sel_t;

    // Avalon-MM slave request carrier.
    typedef struct packed
    {
        logic [3:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } csrl_req_t;

    // Two port outputs with their enables.
    typedef struct packed
    {
        logic out1;
        logic out2;
        logic oe1;
        logic oe2;
    } csrl_port_t;

endpackage

// file: testbench/csrl_far_side.sv
// Model of the comparators and port pins that surround the comparator SR latch.
`timescale 1ns/100ps
module csrl_far_side
    import csrl_pkg::*;
(
    input  wire logic       analog1,
    input  wire logic       analog2,
    input  wire logic [1:0] pin_direction,
    input  wire csrl_port_t port_out,
    output logic            cmp1_result,
    output logic            cmp2_result,
    output logic [1:0]      pin
);
    // Comparator results follow the analog levels that the bench commands.
    assign cmp1_result = analog1;
    assign cmp2_result = analog2;
    // A pin is driven only with its direction bit clear and its enable set; otherwise the pull-up wins.
    assign pin[1] = (port_out.oe1 && !pin_direction[1]) ? port_out.out1 : 1'b1;
    assign pin[0] = (port_out.oe2 && !pin_direction[0]) ? port_out.out2 : 1'b1;
endmodule

// file: testbench/tb_comparator_sr_latch.sv
// Self-checking bench of the comparator SR latch block.
`timescale 1ns/100ps
module tb_comparator_sr_latch
    import csrl_pkg::*;
;
    logic        mclk;
    logic        nrst;
    csrl_req_t   req;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        cmp1_result, cmp2_result, a1, a2, latch_q, eq, p1, p2;
    logic [1:0]  pin_dir, pin, sel;
    csrl_port_t  port_out;
    logic [31:0] rq;
    int          bad_count, cmp_count, i, k, n, per;

    csrl_latch i_csrl_latch (.mclk(mclk), .nrst(nrst), .avs_address(req.address), .avs_read(req.read),
        .avs_write(req.write), .avs_writedata(req.writedata), .avs_byteenable(req.byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cmp1_result(cmp1_result),
        .cmp2_result(cmp2_result), .port_out(port_out), .latch_q(latch_q));

    csrl_far_side i_csrl_far_side (.analog1(a1), .analog2(a2), .pin_direction(pin_dir), .port_out(port_out),
        .cmp1_result(cmp1_result), .cmp2_result(cmp2_result), .pin(pin));

    // The clock toggles every half period.
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Compare one value and count it.
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One bus cycle held until waitrequest is sampled low.
    task automatic bus(input logic [3:0] ad, input logic w, input logic [7:0] d, input logic [3:0] be);
        req <= '{ad, !w, w, {24'h0, d}, be};
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        rq = avs_readdata;
        req <= '{4'h0, 1'b0, 1'b0, 32'h0000_0000, 4'h0};
        if (n >= 50)
            chk("waitrequest", 0, 1);
        @(posedge mclk);
    endtask

    task automatic wr(input logic [3:0] ad, input logic [7:0] d);
        bus(ad, 1'b1, d, 4'hF);
    endtask

    task automatic rd(input logic [3:0] ad, input logic [7:0] e);
        bus(ad, 1'b0, 8'h00, 4'hF);
        chk("readdata", {24'h0, e}, rq);
    endtask

    // Latch state one edge on, sampled before that edge's updates land.
    task automatic qchk(input logic e);
        @(posedge mclk);
        chk("latch_q", e, latch_q);
    endtask

    // Expected output pair for a select code.
    function automatic logic [1:0] mux(input logic [1:0] s, input logic c1, input logic c2, input logic q);
        case (s)
            2'h0: mux = {c1, c2};
            2'h1: mux = {c1, q};
            2'h2: mux = {q, c2};
            default: mux = {q, ~q};
        endcase
    endfunction

    task automatic results();
        if (bad_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // A hang counts as a mismatch and ends the run.
    initial
    begin
        #300000;
        bad_count++;
        results();
    end

    // Main sequence.
    initial
    begin
        nrst = 1'b0;
        req = '0;
        a1 = 1'b1;
        a2 = 1'b0;
        pin_dir = 2'h0;
        void'($urandom(13481));
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        repeat (2) @(posedge mclk);
        chk("port", 4'h8, port_out);
        chk("pin", 2'h3, pin);
        for (i = 0; i < 4; i++)
            rd(4'(i * 4), (i == 0) ? {1'b0, a1, 6'h00} : (i == 1) ? {1'b0, a2, 6'h00} : 8'h00);
        wr(4'h0, 8'hFF);
        rd(4'h0, 8'hFF);
        wr(4'h4, 8'hFF);
        rd(4'h4, 8'hBF);
        wr(4'hC, 8'hFF);
        rd(4'hC, 8'hC0);
        bus(4'hC, 1'b1, 8'h00, 4'h0);
        rd(4'hC, 8'hC0);
        wr(4'h2, 8'hFF);
        rd(4'h2, 8'h00);
        a1 <= 1'b0;
        // Software pulses, alone and together.
        wr(4'h8, 8'h08);
        qchk(1'b1);
        rd(4'h8, 8'h00);
        wr(4'h8, 8'hCC);
        qchk(1'b0);
        rd(4'h8, 8'hC0);
        wr(4'h8, 8'h04);
        qchk(1'b0);
        // Random comparator traffic under every select code.
        for (k = 0; k < 4; k++)
        begin
            sel = 2'(k);
            pin_dir <= 2'($urandom);
            a1 <= 1'b0;
            a2 <= 1'b0;
            wr(4'h0, {1'($urandom), 7'h20});
            wr(4'h4, {1'($urandom), 7'h20});
            wr(4'h8, {sel, 6'h34});
            qchk(1'b0);
            eq = 1'b0;
            p1 = 1'b0;
            p2 = 1'b0;
            for (i = 0; i < 40; i++)
            begin
                chk("latch_q", eq, latch_q);
                chk("port", {mux(sel, p1, p2, eq), 2'h3}, port_out);
                p1 = a1;
                p2 = a2;
                eq = p2 ? 1'b0 : (p1 ? 1'b1 : eq);
                a1 <= 1'($urandom);
                a2 <= ($urandom % 4) == 0;
                @(posedge mclk);
            end
        end
        a1 <= 1'b0;
        a2 <= 1'b0;
        // Set clock period for every rate code, measured between two ticks.
        for (k = 0; k < 4; k++)
        begin
            per = 4 << (2 * k);
            wr(4'hC, {2'(k), 6'h00});
            wr(4'h8, 8'h11);
            repeat (2)
            begin
                a2 <= 1'b1;
                @(posedge mclk);
                a2 <= 1'b0;
                n = 1;
                do
                begin
                    @(posedge mclk);
                    n++;
                end
                while (latch_q !== 1'b1 && n < 600);
            end
            chk("tick", per, n);
        end
        // With the set clock off the latch stays reset.
        wr(4'h8, 8'h14);
        k = 0;
        repeat (300)
        begin
            @(posedge mclk);
            if (latch_q !== 1'b0)
                k++;
        end
        chk("idle_q", 0, k);
        results();
    end
endmodule
